// ===== bench/port_pin_control_ext_irq_tb.sv
// Purpose: Self-checking bench for the port pin block
// Assumes: Pin models on both ports
// Notes:   Pins move at clock edges or 1ns after them, so sampling is race free
`timescale 1ns/10ps
`include "ppcx_defs.svh"
module port_pin_control_ext_irq_tb;
  logic clk_in = 1'b0, sys_rst_in = 1'b1;
  logic [`PPCX_ADDR_W-1:0] addr = '0;
  ppcx_pkg::ppcx_byte_t wdata = 8'h00, rdata, p0_in, p1_in, p0_out, p1_out, p0_oe, p1_oe;
  ppcx_pkg::ppcx_byte_t p0_pe, p1_pe, p0_pu, p1_pu, x0_en = 8'h00, x1_en = 8'h00;
  ppcx_pkg::ppcx_byte_t x0_val = 8'h00, x1_val = 8'h00;
  logic wr = 1'b0, rd = 1'b0, mask = 1'b0, gen = 1'b0, txa = 1'b0, txd = 1'b0;
  logic irq, sb, rx, scan, sb_seen = 1'b0;
  int n_mismatch = 0, checks_done = 0;
  initial forever #4 clk_in = ~clk_in;
  ppcx_port_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .module0_irq_mask_in(mask), .global_irq_enable_in(gen), .irq_req_out(irq),
    .switchback_out(sb), .serial_tx_active_in(txa), .serial_tx_data_in(txd),
    .serial_rx_pin_out(rx), .scan_pins_en_out(scan), .port0_pin_in(p0_in),
    .port1_pin_in(p1_in), .port0_pin_out(p0_out), .port1_pin_out(p1_out),
    .port0_pin_oe_out(p0_oe), .port1_pin_oe_out(p1_oe), .port0_pull_en_out(p0_pe),
    .port1_pull_en_out(p1_pe), .port0_pull_up_out(p0_pu), .port1_pull_up_out(p1_pu));
  ppcx_pin_model u_m0 (.clk_in(clk_in), .oe_in(p0_oe), .val_in(p0_out), .pull_en_in(p0_pe),
    .pull_up_in(p0_pu), .ext_en_in(x0_en), .ext_val_in(x0_val), .level_out(p0_in));
  ppcx_pin_model u_m1 (.clk_in(clk_in), .oe_in(p1_oe), .val_in(p1_out), .pull_en_in(p1_pe),
    .pull_up_in(p1_pu), .ext_en_in(x1_en), .ext_val_in(x1_val), .level_out(p1_in));
  always @(posedge clk_in) if (sb === 1'b1) sb_seen <= 1'b1;
  task automatic chk(input ppcx_pkg::ppcx_byte_t got, input ppcx_pkg::ppcx_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [`PPCX_ADDR_W-1:0] a, input ppcx_pkg::ppcx_byte_t d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [`PPCX_ADDR_W-1:0] a, input ppcx_pkg::ppcx_byte_t m, e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  task automatic t_reset();
    chk(p0_oe | p1_oe, 8'h00);
    chk(p0_pe & p1_pe & p0_pu & p1_pu, 8'hff);
    chk({6'h00, scan, irq}, 8'h02);
    rd_chk(`PPCX_OFF_SPEC, 8'hff, `PPCX_RST_SPEC);
  endtask
  task automatic t_port();
    wr_reg(`PPCX_OFF_OUT0, 8'ha8);
    wr_reg(`PPCX_OFF_DIR0, 8'hf8);
    settle(1);
    chk(p0_oe, 8'hf8);
    chk(p0_out, 8'ha8);
    chk(p0_pe & 8'h07, 8'h00);
    wr_reg(`PPCX_OFF_IN0, 8'h00);
    settle(3);
    rd_chk(`PPCX_OFF_IN0, 8'hf8, 8'ha8);
    rd_chk(5'h1f, 8'hff, 8'h00);
    // Open drain: latch low first, then direction alone moves the pin
    wr_reg(`PPCX_OFF_OUT0, 8'ha0);
    settle(1);
    chk(p0_out & p0_oe & 8'h08, 8'h00);
    wr_reg(`PPCX_OFF_DIR0, 8'hf0);
    settle(1);
    chk((p0_oe | p0_pe) & 8'h08, 8'h00);
    wr_reg(`PPCX_OFF_DIR0, 8'h00);
    wr_reg(`PPCX_OFF_OUT0, 8'hff);
    settle(1);
    chk(p0_pe, 8'hff);
    // Port 1 drive path; restore latch first so no pin floats
    wr_reg(`PPCX_OFF_OUT1, 8'hf5);
    wr_reg(`PPCX_OFF_DIR1, 8'h0f);
    settle(1);
    chk(p1_oe, 8'h0f);
    chk(p1_out, 8'h05);
    chk(p1_pe, 8'hf0);
    wr_reg(`PPCX_OFF_OUT1, 8'hff);
    wr_reg(`PPCX_OFF_DIR1, 8'h00);
    settle(1);
    chk(p1_out | p1_oe, 8'h00);
    chk(p1_pe, 8'hff);
  endtask
  task automatic t_irq();
    @(posedge clk_in);
    mask <= 1'b1;
    gen <= 1'b1;
    wr_reg(`PPCX_OFF_EIE_B, 8'hff);
    wr_reg(`PPCX_OFF_EIES_B, 8'h0f);
    wr_reg(`PPCX_OFF_EIE_A, 8'h07);
    wr_reg(`PPCX_OFF_EIES_A, 8'h07);
    // Floating pins in the port test left stale flags behind
    wr_reg(`PPCX_OFF_EIF_A, 8'hff);
    wr_reg(`PPCX_OFF_EIF_B, 8'hff);
    settle(3);
    sb_seen = 1'b0;
    x1_en <= 8'hff;
    x0_en <= 8'h07;
    settle(6);
    rd_chk(`PPCX_OFF_EIF_B, 8'hff, 8'h0f);
    rd_chk(`PPCX_OFF_EIF_A, 8'hff, 8'h07);
    chk({5'h00, rx, sb_seen, irq}, 8'h03);
    rd_chk(`PPCX_OFF_IN1, 8'hff, 8'h00);
    wr_reg(`PPCX_OFF_EIF_B, 8'h0f);
    wr_reg(`PPCX_OFF_EIF_A, 8'h07);
    settle(2);
    chk({7'h00, irq}, 8'h00);
    x1_en <= 8'h00;
    settle(6);
    rd_chk(`PPCX_OFF_EIF_B, 8'hff, 8'hf0);
    mask <= 1'b0;
    settle(2);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`PPCX_OFF_EIF_B, 8'hff);
    wr_reg(`PPCX_OFF_EIE_B, 8'h00);
    settle(2);
    mask <= 1'b1;
    sb_seen = 1'b0;
    x1_en <= 8'hff;
    settle(6);
    rd_chk(`PPCX_OFF_EIF_B, 8'hff, 8'h0f);
    chk({6'h00, sb_seen, irq}, 8'h00);
    x0_en <= 8'h00;
    wr_reg(`PPCX_OFF_EIF_B, 8'hff);
  endtask
  task automatic t_tx();
    wr_reg(`PPCX_OFF_SPEC, 8'h07);
    settle(1);
    txa <= 1'b1;
    txd <= 1'b1;
    settle(1);
    chk(p0_oe & 8'h06, 8'h06);
    chk(p0_out & 8'h06, 8'h02);
    txd <= 1'b0;
    settle(1);
    chk(p0_out & 8'h06, 8'h00);
    txa <= 1'b0;
    settle(1);
    chk(p0_oe & 8'h06, 8'h00);
    chk(p0_pe & p0_pu & 8'h06, 8'h06);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle(1);
    t_reset();
    t_port();
    t_irq();
    t_tx();
    close_out();
  end
  // Whole run needs about 110 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
endmodule

// ===== bench/ppcx_pin_model.sv
// Purpose: Board side of one 8-bit port
// Assumes: Bench chooses which pins an outside source drives
// Notes:   An undriven, unpulled pin toggles so its value is never trusted
`timescale 1ns/10ps
module ppcx_pin_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] val_in,
  input  wire logic [7:0] pull_en_in,
  input  wire logic [7:0] pull_up_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] level_out
);
  logic [7:0] last_q;
  always_ff @(posedge clk_in) last_q <= level_out;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) level_out[i] = val_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pull_en_in[i]) level_out[i] = pull_up_in[i];
      else level_out[i] = ~last_q[i];
    end
  end
endmodule

// ===== bench/ppcx_port_ctrl_assertions.sv
// Purpose: Port-level checks of the port pin block
// Assumes: Sees only the ports of ppcx_port_ctrl
// Notes:   Bound at the foot of this file
`timescale 1ns/10ps
`include "ppcx_defs.svh"
module ppcx_port_ctrl_chk (
  input wire logic                    clk_in,
  input wire logic                    sys_rst_in,
  input wire logic [`PPCX_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0]              reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    reg_rd_in,
  input wire logic [7:0]              reg_rdata_out,
  input wire logic                    module0_irq_mask_in,
  input wire logic                    global_irq_enable_in,
  input wire logic                    irq_req_out,
  input wire logic                    switchback_out,
  input wire logic                    scan_pins_en_out,
  input wire logic                    serial_rx_pin_out,
  input wire logic [7:0]              port0_pin_in,
  input wire logic [7:0]              port1_pin_in,
  input wire logic [7:0]              port0_pin_out,
  input wire logic [7:0]              port0_pin_oe_out,
  input wire logic [7:0]              port0_pull_en_out,
  input wire logic [7:0]              port0_pull_up_out
);
  // Synchronisers hold ff through reset, so latency checks wait it out
  logic [2:0] since_rst_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) since_rst_q <= 3'h0;
    else if (since_rst_q != 3'h7) since_rst_q <= since_rst_q + 3'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RST_STATE: assert property (
    $past(sys_rst_in) |-> port0_pin_oe_out == 8'h00 && port0_pull_en_out == 8'hff
      && port0_pull_up_out == 8'hff && scan_pins_en_out && !irq_req_out)
    else $error("reset state wrong");
  AST_RD_IDLE: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("stray read data");
  AST_IN_READ: assert property (
    reg_rd_in && reg_addr_in == `PPCX_OFF_IN1 && since_rst_q > 3'h3
      |=> reg_rdata_out == $past(port1_pin_in, 3)) else $error("input read wrong");
  AST_RX_FEED: assert property (
    since_rst_q > 3'h3 |-> serial_rx_pin_out == $past(port0_pin_in[0], 3))
    else $error("rx feed wrong");
  AST_OUT_GATED: assert property (
    (port0_pin_out & ~port0_pin_oe_out) == 8'h00) else $error("drive value leaks");
  AST_IRQ_GATE: assert property (
    irq_req_out |-> $past(module0_irq_mask_in) && $past(global_irq_enable_in))
    else $error("irq not gated");
  AST_SB_IRQ: assert property (
    switchback_out && module0_irq_mask_in && global_irq_enable_in |=> irq_req_out)
    else $error("irq missing after edge");
  AST_DIR_OE: assert property (
    reg_wr_in && reg_addr_in == `PPCX_OFF_DIR0
      |-> ##2 port0_pin_oe_out[7:3] == $past(reg_wdata_in[7:3], 2))
    else $error("direction not applied");
endmodule

bind ppcx_port_ctrl ppcx_port_ctrl_chk u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .module0_irq_mask_in(module0_irq_mask_in),
  .global_irq_enable_in(global_irq_enable_in), .irq_req_out(irq_req_out),
  .switchback_out(switchback_out), .scan_pins_en_out(scan_pins_en_out),
  .serial_rx_pin_out(serial_rx_pin_out), .port0_pin_in(port0_pin_in),
  .port1_pin_in(port1_pin_in), .port0_pin_out(port0_pin_out),
  .port0_pin_oe_out(port0_pin_oe_out), .port0_pull_en_out(port0_pull_en_out),
  .port0_pull_up_out(port0_pull_up_out)
);

// ===== hw/ppcx_port_ctrl.sv
// Purpose: Per-pin direction, output, pull, external interrupt and special-function mux
// Assumes: Single clock clk_in, synchronous active-high reset, plain register port
// Notes:   Flags are write-one-to-clear; a new edge wins over the clear
//
// Behaviour
// - Output direction without special function drives the output-latch value.
// - Input direction uses the output-latch bit as weak pull enable.
// - Input registers always return synchronised pin levels, whatever the direction.
// - Every pin of both ports has enable, flag and edge-select bits.
// - Edge-select bit picks rising or falling transition per pin.
// - A detected transition of selected polarity sets the pin's flag.
// - Request raised only when flag and pin enable, mask and global set.
// - Any valid interrupt edge issues a stop-mode switchback trigger.
// - After reset special functions are off except boundary-scan pins.
// - An enabled special function overrides direction and output latch; the code does so only while serial_tx_active_in is high.
// - Alternate functions leave direction and output under normal control.
// - Port 0 pin 0 always feeds the serial receiver input.
// - While transmitting, port 0 pin 1 carries transmit data, else configured pull; the code falls back to direction and output latch.
// - While transmitting, port 0 pin 2 drives low, else configured pull; the code falls back to direction and output latch.
// - Port 0 pins 0 to 2 become interrupt inputs 0 to 2 when enabled.
// - Every pin leaves reset as an input with weak pullup.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ppcx_defs.svh"

module ppcx_port_ctrl (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  // Register port
  input  wire logic [`PPCX_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [7:0]              reg_rdata_out,
  // Interrupt gating from the core
  input  wire logic                    module0_irq_mask_in,
  input  wire logic                    global_irq_enable_in,
  output logic                         irq_req_out,
  output logic                         switchback_out,
  // Serial port
  input  wire logic                    serial_tx_active_in,
  input  wire logic                    serial_tx_data_in,
  output logic                         serial_rx_pin_out,
  // Boundary-scan function enable
  output logic                         scan_pins_en_out,
  // Pins: input, output value, output enable, pull enable and pull direction
  input  wire logic [7:0]              port0_pin_in,
  input  wire logic [7:0]              port1_pin_in,
  output logic      [7:0]              port0_pin_out,
  output logic      [7:0]              port1_pin_out,
  output logic      [7:0]              port0_pin_oe_out,
  output logic      [7:0]              port1_pin_oe_out,
  output logic      [7:0]              port0_pull_en_out,
  output logic      [7:0]              port1_pull_en_out,
  output logic      [7:0]              port0_pull_up_out,
  output logic      [7:0]              port1_pull_up_out
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  ppcx_pkg::ppcx_byte_t port0_direction_reg_q;
  ppcx_pkg::ppcx_byte_t port1_direction_reg_q;
  ppcx_pkg::ppcx_byte_t port0_output_latch_reg_q;
  ppcx_pkg::ppcx_byte_t port1_output_latch_reg_q;
  ppcx_pkg::ppcx_byte_t port0_pull_dir_q;
  ppcx_pkg::ppcx_byte_t port1_pull_dir_q;
  ppcx_pkg::ppcx_byte_t ext_irq_enable_reg_a_q;
  ppcx_pkg::ppcx_byte_t ext_irq_enable_reg_b_q;
  ppcx_pkg::ppcx_byte_t ext_irq_edge_sel_reg_a_q;
  ppcx_pkg::ppcx_byte_t ext_irq_edge_sel_reg_b_q;
  ppcx_pkg::ppcx_byte_t ext_irq_flag_reg_a_q;
  ppcx_pkg::ppcx_byte_t ext_irq_flag_reg_b_q;
  ppcx_pkg::ppcx_byte_t special_en_q;
  logic [15:0]          pin_meta_q;
  logic [15:0]          pin_sync_q;
  logic [15:0]          pin_prev_q;
  logic [15:0]          edge_hit_d;

  function automatic logic hit(input logic [`PPCX_ADDR_W-1:0] off);
    hit = reg_wr_in && (reg_addr_in == off);
  endfunction

  // Rising when select is 0, falling when select is 1
  function automatic ppcx_pkg::ppcx_byte_t edges(input ppcx_pkg::ppcx_byte_t cur,
                                                 input ppcx_pkg::ppcx_byte_t prv,
                                                 input ppcx_pkg::ppcx_byte_t sel);
    edges = ((cur & ~prv) & ~sel) | ((~cur & prv) & sel);
  endfunction

  // ------------------------------------------------------------
  // Configuration writes
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port0_direction_reg_q <= `PPCX_RST_DIR;
      port1_direction_reg_q <= `PPCX_RST_DIR;
    end else begin
      if (hit(`PPCX_OFF_DIR0)) begin
        port0_direction_reg_q <= reg_wdata_in;
      end
      if (hit(`PPCX_OFF_DIR1)) begin
        port1_direction_reg_q <= reg_wdata_in;
      end
    end
  end

  // Latch resets high so input pins leave reset pulled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port0_output_latch_reg_q <= `PPCX_RST_OUT;
      port1_output_latch_reg_q <= `PPCX_RST_OUT;
    end else begin
      if (hit(`PPCX_OFF_OUT0)) begin
        port0_output_latch_reg_q <= reg_wdata_in;
      end
      if (hit(`PPCX_OFF_OUT1)) begin
        port1_output_latch_reg_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port0_pull_dir_q <= `PPCX_RST_PULL;
      port1_pull_dir_q <= `PPCX_RST_PULL;
    end else begin
      if (hit(`PPCX_OFF_PULL0)) begin
        port0_pull_dir_q <= reg_wdata_in;
      end
      if (hit(`PPCX_OFF_PULL1)) begin
        port1_pull_dir_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_irq_enable_reg_a_q <= `PPCX_RST_ZERO;
      ext_irq_enable_reg_b_q <= `PPCX_RST_ZERO;
    end else begin
      if (hit(`PPCX_OFF_EIE_A)) begin
        ext_irq_enable_reg_a_q <= reg_wdata_in;
      end
      if (hit(`PPCX_OFF_EIE_B)) begin
        ext_irq_enable_reg_b_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_irq_edge_sel_reg_a_q <= `PPCX_RST_ZERO;
      ext_irq_edge_sel_reg_b_q <= `PPCX_RST_ZERO;
    end else begin
      if (hit(`PPCX_OFF_EIES_A)) begin
        ext_irq_edge_sel_reg_a_q <= reg_wdata_in;
      end
      if (hit(`PPCX_OFF_EIES_B)) begin
        ext_irq_edge_sel_reg_b_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      special_en_q <= `PPCX_RST_SPEC;
    end else if (hit(`PPCX_OFF_SPEC)) begin
      special_en_q <= reg_wdata_in;
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_meta_q <= 16'hffff;
      pin_sync_q <= 16'hffff;
      pin_prev_q <= 16'hffff;
    end else begin
      pin_meta_q <= {port1_pin_in, port0_pin_in};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign edge_hit_d = {edges(pin_sync_q[15:8], pin_prev_q[15:8], ext_irq_edge_sel_reg_b_q),
                       edges(pin_sync_q[7:0], pin_prev_q[7:0], ext_irq_edge_sel_reg_a_q)};

  // ------------------------------------------------------------
  // Flags: write one to clear, a new edge wins
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_irq_flag_reg_a_q <= `PPCX_RST_ZERO;
      ext_irq_flag_reg_b_q <= `PPCX_RST_ZERO;
    end else begin
      ext_irq_flag_reg_a_q <= (ext_irq_flag_reg_a_q &
                               ~(hit(`PPCX_OFF_EIF_A) ? reg_wdata_in : 8'h00))
                              | edge_hit_d[7:0];
      ext_irq_flag_reg_b_q <= (ext_irq_flag_reg_b_q &
                               ~(hit(`PPCX_OFF_EIF_B) ? reg_wdata_in : 8'h00))
                              | edge_hit_d[15:8];
    end
  end

  // ------------------------------------------------------------
  // Interrupt request and switchback
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_req_out    <= 1'b0;
      switchback_out <= 1'b0;
    end else begin
      irq_req_out <= (|((ext_irq_flag_reg_a_q & ext_irq_enable_reg_a_q) |
                        (ext_irq_flag_reg_b_q & ext_irq_enable_reg_b_q)))
                     && module0_irq_mask_in && global_irq_enable_in;
      // Only enabled pins count as interrupt pins for wake-up
      switchback_out <= |(edge_hit_d &
                          {ext_irq_enable_reg_b_q, ext_irq_enable_reg_a_q});
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `PPCX_OFF_DIR0) begin
        reg_rdata_out <= port0_direction_reg_q;
      end else if (reg_addr_in == `PPCX_OFF_DIR1) begin
        reg_rdata_out <= port1_direction_reg_q;
      end else if (reg_addr_in == `PPCX_OFF_OUT0) begin
        reg_rdata_out <= port0_output_latch_reg_q;
      end else if (reg_addr_in == `PPCX_OFF_OUT1) begin
        reg_rdata_out <= port1_output_latch_reg_q;
      end else if (reg_addr_in == `PPCX_OFF_PULL0) begin
        reg_rdata_out <= port0_pull_dir_q;
      end else if (reg_addr_in == `PPCX_OFF_PULL1) begin
        reg_rdata_out <= port1_pull_dir_q;
      end else if (reg_addr_in == `PPCX_OFF_IN0) begin
        reg_rdata_out <= pin_sync_q[7:0];
      end else if (reg_addr_in == `PPCX_OFF_IN1) begin
        reg_rdata_out <= pin_sync_q[15:8];
      end else if (reg_addr_in == `PPCX_OFF_EIE_A) begin
        reg_rdata_out <= ext_irq_enable_reg_a_q;
      end else if (reg_addr_in == `PPCX_OFF_EIE_B) begin
        reg_rdata_out <= ext_irq_enable_reg_b_q;
      end else if (reg_addr_in == `PPCX_OFF_EIES_A) begin
        reg_rdata_out <= ext_irq_edge_sel_reg_a_q;
      end else if (reg_addr_in == `PPCX_OFF_EIES_B) begin
        reg_rdata_out <= ext_irq_edge_sel_reg_b_q;
      end else if (reg_addr_in == `PPCX_OFF_EIF_A) begin
        reg_rdata_out <= ext_irq_flag_reg_a_q;
      end else if (reg_addr_in == `PPCX_OFF_EIF_B) begin
        reg_rdata_out <= ext_irq_flag_reg_b_q;
      end else if (reg_addr_in == `PPCX_OFF_SPEC) begin
        reg_rdata_out <= special_en_q;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic [7:0] p0_oe_d;
  logic [7:0] p0_val_d;
  logic [7:0] p0_pen_d;
  logic       tx_spec;
  logic       tx_driver_enable_n_spec;

  assign tx_spec   = special_en_q[`PPCX_SPEC_TX_BIT] && serial_tx_active_in;
  assign tx_driver_enable_n_spec = special_en_q[`PPCX_SPEC_TX_DRIVER_ENABLE_N_BIT] && serial_tx_active_in;

  // Alternate (interrupt) functions never touch drive: standard mux only
  always_comb begin
    p0_oe_d  = port0_direction_reg_q;
    p0_val_d = port0_output_latch_reg_q & port0_direction_reg_q;
    p0_pen_d = port0_output_latch_reg_q & ~port0_direction_reg_q;
    if (tx_spec) begin
      p0_oe_d[`PPCX_PIN_TX]  = 1'b1;
      p0_val_d[`PPCX_PIN_TX] = serial_tx_data_in;
      p0_pen_d[`PPCX_PIN_TX] = 1'b0;
    end
    if (tx_driver_enable_n_spec) begin
      p0_oe_d[`PPCX_PIN_TX_DRIVER_ENABLE_N]  = 1'b1;
      p0_val_d[`PPCX_PIN_TX_DRIVER_ENABLE_N] = 1'b0;
      p0_pen_d[`PPCX_PIN_TX_DRIVER_ENABLE_N] = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port0_pin_oe_out  <= `PPCX_RST_ZERO;
      port0_pin_out     <= `PPCX_RST_ZERO;
      port0_pull_en_out <= `PPCX_RST_PULL;
      port0_pull_up_out <= `PPCX_RST_PULL;
    end else begin
      port0_pin_oe_out  <= p0_oe_d;
      port0_pin_out     <= p0_val_d;
      port0_pull_en_out <= p0_pen_d;
      port0_pull_up_out <= port0_pull_dir_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port1_pin_oe_out  <= `PPCX_RST_ZERO;
      port1_pin_out     <= `PPCX_RST_ZERO;
      port1_pull_en_out <= `PPCX_RST_PULL;
      port1_pull_up_out <= `PPCX_RST_PULL;
    end else begin
      port1_pin_oe_out  <= port1_direction_reg_q;
      port1_pin_out     <= port1_output_latch_reg_q & port1_direction_reg_q;
      port1_pull_en_out <= port1_output_latch_reg_q & ~port1_direction_reg_q;
      port1_pull_up_out <= port1_pull_dir_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scan_pins_en_out <= 1'b1;
    end else begin
      scan_pins_en_out <= special_en_q[`PPCX_SPEC_SCAN_BIT];
    end
  end

  // Receiver sees the synchronised pin whatever the configuration
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      serial_rx_pin_out <= 1'b1;
    end else begin
      serial_rx_pin_out <= pin_sync_q[`PPCX_PIN_RX];
    end
  end

endmodule

// ===== include/ppcx_defs.svh
// Purpose: Offsets, reset values and field positions of the port pin block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are word indices on the local register port
`ifndef PPCX_DEFS_SVH
`define PPCX_DEFS_SVH

`define PPCX_ADDR_W          5
`define PPCX_OFF_DIR0        5'h00
`define PPCX_OFF_DIR1        5'h01
`define PPCX_OFF_OUT0        5'h02
`define PPCX_OFF_OUT1        5'h03
`define PPCX_OFF_PULL0       5'h04
`define PPCX_OFF_PULL1       5'h05
`define PPCX_OFF_IN0         5'h06
`define PPCX_OFF_IN1         5'h07
`define PPCX_OFF_EIE_A       5'h08
`define PPCX_OFF_EIE_B       5'h09
`define PPCX_OFF_EIES_A      5'h0a
`define PPCX_OFF_EIES_B      5'h0b
`define PPCX_OFF_EIF_A       5'h0c
`define PPCX_OFF_EIF_B       5'h0d
`define PPCX_OFF_SPEC        5'h0e

`define PPCX_RST_DIR         8'h00
`define PPCX_RST_OUT         8'hff
`define PPCX_RST_PULL        8'hff
`define PPCX_RST_ZERO        8'h00
// Special enable reg: bit0 tx pin special, bit1 tx enable special, bit2 scan
`define PPCX_RST_SPEC        8'h04
`define PPCX_SPEC_TX_BIT     0
`define PPCX_SPEC_TX_DRIVER_ENABLE_N_BIT   1
`define PPCX_SPEC_SCAN_BIT   2
`define PPCX_PIN_RX          0
`define PPCX_PIN_TX          1
`define PPCX_PIN_TX_DRIVER_ENABLE_N        2

`endif

// ===== include/ppcx_pkg.sv
// Purpose: Types for the port pin block
// Assumes: Two 8-bit ports
// Notes:   Constants live in ppcx_defs.svh
package ppcx_pkg;
  typedef logic [7:0] ppcx_byte_t;
  typedef enum logic [1:0] {
    PPCX_PIN_HIZ,
    PPCX_PIN_PULL,
    PPCX_PIN_DRIVE
  } ppcx_pin_mode_t;
endpackage
